// [verilog/tcr_top.sv]
// Transmit control/status register with APB access and interrupt
// Assumes the transmit MAC supplies event pulses synchronous to pclk
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module tcr_top
   import tcr_pkg::*;
#(
   parameter int DEFER_CYC = TCR_DEFER_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic soft_reset,
   input wire logic tx_start,
   input wire logic [15:0] descriptor_config_word,
   input wire logic preamble_start,
   input wire logic sfd_done,
   input wire logic tx_last_byte,
   input wire logic deferring,
   input wire logic carrier_sense,
   input wire logic collision,
   input wire logic tx_end,
   input wire logic monitored_bad,
   input wire logic fifo_underrun,
   input wire logic byte_count_mismatch,
   input wire logic status_wr_done,
   output logic status_wr_req,
   output logic [15:0] descriptor_status_word,
   output logic tx_abort,
   output logic frame_check_omit,
   output logic irq
);
   import tcr_pkg::*;
   // ****************************************************************
   // Bus front end
   // ****************************************************************
   tcr_apb_if bus ();
   tcr_apb u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .bus(bus)
   );
   // ****************************************************************
   // State
   // ****************************************************************
   tcr_state_t state;
   tcr_state_t next_state;
   logic [15:0] transmit_control;
   logic [4:0] coll_count;
   logic [21:0] defer_cnt;
   logic [11:0] slot_cnt;
   logic slot_run;
   logic crs_window;
   logic [TCR_IRQ_W-1:0] interrupt_status_reg;
   logic [TCR_IRQ_W-1:0] irq_mask;
   logic prev_programmable_tx_interrupt;
   // ****************************************************************
   // Decode and control terms
   // ****************************************************************
   wire sel_ctl = bus.addr == TCR_ADDR_TXCTL;
   wire sel_ist = bus.addr == TCR_ADDR_ISTAT;
   wire sel_msk = bus.addr == TCR_ADDR_IMASK;
   wire sel_dst = bus.addr == TCR_ADDR_DSTAT;
   assign bus.err = !(sel_ctl || sel_ist || sel_msk || sel_dst);
   assign bus.rdata = sel_ctl ? {16'h0000, transmit_control} :
                      sel_ist ? {30'h0000_0000, interrupt_status_reg} :
                      sel_msk ? {30'h0000_0000, irq_mask} :
                      sel_dst ? {16'h0000, descriptor_status_word} : 32'h0000_0000;
   wire in_xmit = state == TCR_XMIT;
   wire start_ok = (state == TCR_IDLE) && tx_start;
   // Deferral timer only runs while enabled
   wire defer_on = in_xmit && deferring && !transmit_control[TCR_B_DEFERRAL_TIMER_DISABLE];
   wire defer_hit = defer_on && (defer_cnt == 22'(DEFER_CYC - 1));
   wire coll_hit = in_xmit && collision && (coll_count == 5'(TCR_MAX_COLL - 1));
   wire late_coll = in_xmit && collision && slot_run
      && (slot_cnt >= 12'(TCR_SLOT_CYC));
   // Timer start: preamble if bit 14 set, else end of delimiter
   wire slot_go = transmit_control[TCR_B_LATE_COLLISION_TIMER_START_SELECT] ? preamble_start : sfd_done;
   wire abort_now = defer_hit || coll_hit;
   wire end_now = in_xmit && (tx_end || abort_now);
   wire programmable_tx_interrupt_seen = start_ok && descriptor_config_word[TCR_B_PROGRAMMABLE_TX_INTERRUPT] && !prev_programmable_tx_interrupt;
   wire [TCR_IRQ_W-1:0] irq_evt = {end_now, programmable_tx_interrupt_seen};
   always_comb begin
      next_state = state;
      unique case (state)
         TCR_IDLE: if (tx_start) next_state = TCR_XMIT;
         TCR_XMIT: if (end_now) next_state = TCR_WBACK;
         TCR_WBACK: if (status_wr_done) next_state = TCR_IDLE;
         default: next_state = TCR_IDLE;
      endcase
   end
   // ****************************************************************
   // Transmit control register; hardware reset only
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_control <= TCR_RESET;
      end else if (ce) begin
         if (start_ok) begin
            // Config bits loaded, start-of-packet status cleared
            transmit_control <= (descriptor_config_word & TCR_CFG_MASK)
               | ((transmit_control & TCR_STAT_MASK & ~TCR_START_CLR)
               | (16'h0001 << TCR_B_NO_CARRIER_FLAG));
         end else if (state == TCR_WBACK && status_wr_done) begin
            transmit_control <= transmit_control & ~TCR_END_CLR;
         end else if (in_xmit) begin
            if (end_now) begin
               // Latch end-of-packet outcome
               transmit_control[TCR_B_PTX] <= !abort_now && !fifo_underrun;
               transmit_control[TCR_B_FU] <= fifo_underrun;
               transmit_control[TCR_B_BCM] <= byte_count_mismatch;
               // Frame check omitted means the monitor cannot flag bad
               transmit_control[TCR_B_PMB] <= monitored_bad && !transmit_control[TCR_B_FRAME_CHECK_OMIT];
            end
            if (defer_hit) transmit_control[TCR_B_EXD] <= 1'b1;
            if (coll_hit) transmit_control[TCR_B_EXC] <= 1'b1;
            if (late_coll) transmit_control[TCR_B_OWC] <= 1'b1;
            if (deferring && coll_count == 5'd0) transmit_control[TCR_B_DEF] <= 1'b1;
            if (collision) transmit_control[TCR_B_DEF] <= 1'b0;
            if (preamble_start) transmit_control[TCR_B_NO_CARRIER_FLAG] <= 1'b1;
            if (crs_window && carrier_sense) transmit_control[TCR_B_NO_CARRIER_FLAG] <= 1'b0;
            if (crs_window && !carrier_sense) transmit_control[TCR_B_CARRIER_LOST_FLAG] <= 1'b1;
         end
         // Only config bits take the write, so status updates are never lost
         if (bus.wr && sel_ctl && !start_ok) begin
            transmit_control[TCR_B_PROGRAMMABLE_TX_INTERRUPT:TCR_B_DEFERRAL_TIMER_DISABLE] <= bus.wdata[TCR_B_PROGRAMMABLE_TX_INTERRUPT:TCR_B_DEFERRAL_TIMER_DISABLE];
         end
      end
   end
   // ****************************************************************
   // Sequencer, counters and timers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= TCR_IDLE;
         coll_count <= 5'd0;
         defer_cnt <= 22'd0;
         slot_cnt <= 12'd0;
         slot_run <= 1'b0;
         crs_window <= 1'b0;
         prev_programmable_tx_interrupt <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         if (start_ok) begin
            coll_count <= 5'd0;
            prev_programmable_tx_interrupt <= descriptor_config_word[TCR_B_PROGRAMMABLE_TX_INTERRUPT];
         end else if (in_xmit && collision) begin
            coll_count <= coll_count + 5'd1;
         end
         defer_cnt <= defer_on ? defer_cnt + 22'd1 : 22'd0;
         // Collision restarts the attempt, so the window restarts too
         if (!in_xmit || collision) begin
            slot_run <= 1'b0;
            slot_cnt <= 12'd0;
         end else if (slot_go) begin
            slot_run <= 1'b1;
            slot_cnt <= 12'd0;
         end else if (slot_run && slot_cnt != 12'hfff) begin
            slot_cnt <= slot_cnt + 12'd1;
         end
         if (!in_xmit || tx_last_byte) crs_window <= 1'b0;
         else if (sfd_done) crs_window <= 1'b1;
      end
   end
   // ****************************************************************
   // Descriptor writeback and MAC controls
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_wr_req <= 1'b0;
         descriptor_status_word <= 16'h0000;
         tx_abort <= 1'b0;
         frame_check_omit <= 1'b0;
      end else if (ce) begin
         tx_abort <= abort_now;
         frame_check_omit <= transmit_control[TCR_B_FRAME_CHECK_OMIT];
         if (state == TCR_XMIT && next_state == TCR_WBACK) status_wr_req <= 1'b1;
         else if (status_wr_done) status_wr_req <= 1'b0;
         if (state == TCR_WBACK) begin
            // Status bits with collision count in the top bits
            // Status is frozen during writeback, so the word is steady from one cycle after status_wr_req rises
            descriptor_status_word <= {coll_count, transmit_control[10:0]};
         end
      end
   end
   // ****************************************************************
   // Interrupts: sticky, write-one-to-clear, set wins over clear
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_status_reg <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end else if (ce) begin
         interrupt_status_reg <= (interrupt_status_reg
            & ~((bus.wr && sel_ist) ? bus.wdata[TCR_IRQ_W-1:0] : '0)) | irq_evt;
         if (bus.wr && sel_msk) irq_mask <= bus.wdata[TCR_IRQ_W-1:0];
         irq <= |(interrupt_status_reg & irq_mask);
      end
   end
endmodule : tcr_top

// [verilog/tcr_pkg.sv]
// Package for the transmit control/status register block
// Assumes a 40 MHz pclk and a 32-bit APB register bus
package tcr_pkg;
   // ****************************************************************
   // Register map (printed offset is an index; byte address = 4 * index)
   // ****************************************************************
   localparam logic [7:0] TCR_IDX_TXCTL = 8'h03;
   localparam logic [11:0] TCR_ADDR_TXCTL = 12'h00c;
   localparam logic [11:0] TCR_ADDR_ISTAT = 12'h010;
   localparam logic [11:0] TCR_ADDR_IMASK = 12'h014;
   localparam logic [11:0] TCR_ADDR_DSTAT = 12'h018;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int TCR_B_PROGRAMMABLE_TX_INTERRUPT = 15;
   localparam int TCR_B_LATE_COLLISION_TIMER_START_SELECT = 14;
   localparam int TCR_B_FRAME_CHECK_OMIT = 13;
   localparam int TCR_B_DEFERRAL_TIMER_DISABLE = 12;
   localparam int TCR_B_EXD = 10;
   localparam int TCR_B_DEF = 9;
   localparam int TCR_B_NO_CARRIER_FLAG = 8;
   localparam int TCR_B_CARRIER_LOST_FLAG = 7;
   localparam int TCR_B_EXC = 6;
   localparam int TCR_B_OWC = 5;
   localparam int TCR_B_PMB = 3;
   localparam int TCR_B_FU = 2;
   localparam int TCR_B_BCM = 1;
   localparam int TCR_B_PTX = 0;
   localparam logic [15:0] TCR_CFG_MASK = 16'hf000;
   localparam logic [15:0] TCR_STAT_MASK = 16'h07ef;
   localparam logic [15:0] TCR_RESET = 16'h0101;
   localparam logic [15:0] TCR_START_CLR = 16'h04c2;
   localparam logic [15:0] TCR_END_CLR = 16'h0220;
   // Interrupt status bits: 0 programmable, 1 transmission done
   localparam int TCR_IRQ_W = 2;
   localparam int TCR_IRQ_PROGRAMMABLE_TX_INTERRUPT = 0;
   localparam int TCR_IRQ_DONE = 1;
   localparam int TCR_MAX_COLL = 16;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int TCR_CLK_KHZ = 40000;
   localparam int TCR_DEFER_US = 3200;
   localparam int TCR_DEFER_CYC = TCR_DEFER_US * TCR_CLK_KHZ / 1000;
   localparam int TCR_SLOT_NS_X10 = 512;
   localparam int TCR_SLOT_CYC = (TCR_SLOT_NS_X10 * 100 + 24) / 25;
   typedef enum logic [2:0] {
      TCR_IDLE = 3'b001,
      TCR_XMIT = 3'b010,
      TCR_WBACK = 3'b100
   } tcr_state_t;
endpackage : tcr_pkg

// [verilog/tcr_apb_if.sv]
// Interface between APB slave and register core
// Assumes one pclk domain
`timescale 1ns/1ps
interface tcr_apb_if;
   logic wr;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic err;
   modport slave (output wr, output addr, output wdata, input rdata, input err);
   modport core (input wr, input addr, input wdata, output rdata, output err);
endinterface : tcr_apb_if

// [verilog/tcr_apb.sv]
// APB slave front end; one wait-free access phase
// Assumes APB3 master, synchronous inputs
`timescale 1ns/1ps
module tcr_apb
   import tcr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   tcr_apb_if.slave bus
);
   wire setup = psel && !penable && !pready;
   assign bus.wr = psel && penable && pwrite && pready && ce;
   assign bus.addr = paddr;
   assign bus.wdata = pwdata;
   // Ready rises one cycle after setup, read data captured with it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= setup;
         prdata <= setup && !pwrite ? bus.rdata : 32'h0000_0000;
         pslverr <= setup && bus.err;
      end
   end
endmodule : tcr_apb

// [verification/tcr_checker.sv]
// Port-level checker for the transmit control/status register block
// Assumes one pclk domain; bound onto every tcr_top instance
`timescale 1ns/1ps
module tcr_checker
   import tcr_pkg::*;
#(
   parameter int DEFER_CYC = TCR_DEFER_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_start,
   input wire logic [15:0] descriptor_config_word,
   input wire logic tx_end,
   input wire logic status_wr_done,
   input wire logic status_wr_req,
   input wire logic [15:0] descriptor_status_word,
   input wire logic tx_abort,
   input wire logic frame_check_omit,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****************************************************************
   // Assertions
   // ****************************************************************
   wire rd_ctl = pready && !pslverr && !pwrite && paddr == TCR_ADDR_TXCTL;
   setup_answer_a: assert property (ce && psel && !penable |=> pready)
      else $error("setup not answered next cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   ctl_zero_a: assert property (
      rd_ctl |-> prdata[31:16] == 16'h0000 && !prdata[11] && !prdata[4])
      else $error("fixed-zero bits of transmit_control read as one");
   wb_req_a: assert property (tx_end |=> status_wr_req)
      else $error("no status write request after end");
   wb_hold_a: assert property (status_wr_req && !status_wr_done |=> status_wr_req)
      else $error("status write request dropped early");
   word_zero_a: assert property (
      status_wr_req && $past(status_wr_req) |-> !descriptor_status_word[4])
      else $error("status word bit 4 set");
   abort_wb_a: assert property (tx_abort |-> ##[0:2] status_wr_req)
      else $error("abort without status write request");
   fcs_cfg_a: assert property (
      tx_start |-> ##2 frame_check_omit == $past(descriptor_config_word[13], 2))
      else $error("frame check omit not loaded from descriptor");
   abort_c: cover property (tx_abort);
   err_c: cover property (pslverr);
   irq_c: cover property ($rose(irq));
endmodule : tcr_checker

bind tcr_top tcr_checker #(.DEFER_CYC(DEFER_CYC)) u_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .tx_start(tx_start),
   .descriptor_config_word(descriptor_config_word), .tx_end(tx_end),
   .status_wr_done(status_wr_done), .status_wr_req(status_wr_req),
   .descriptor_status_word(descriptor_status_word), .tx_abort(tx_abort),
   .frame_check_omit(frame_check_omit), .irq(irq));

// [verification/tb_top.sv]
// Self-checking bench for the transmit control/status register block
// Assumes tcr_top and tcr_checker compiled beforehand
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   import tcr_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, r;
   logic soft_reset = 0, tx_start = 0, preamble_start = 0, sfd_done = 0, tx_last_byte = 0;
   logic deferring = 0, carrier_sense = 0, collision = 0, tx_end = 0, fifo_underrun = 0;
   logic byte_count_mismatch = 0, status_wr_done = 0, status_wr_req, tx_abort, frame_check_omit;
   logic [15:0] descriptor_config_word = 16'h0000, descriptor_status_word, sw;
   logic err, ab;
   int n_mismatch = 0, checks = 0;
   // Short deferral limit keeps the run small
   tcr_top #(.DEFER_CYC(50)) DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .soft_reset(soft_reset), .tx_start(tx_start),
      .descriptor_config_word(descriptor_config_word), .preamble_start(preamble_start),
      .sfd_done(sfd_done), .tx_last_byte(tx_last_byte), .deferring(deferring),
      .carrier_sense(carrier_sense), .collision(collision), .tx_end(tx_end),
      .monitored_bad(1'b0), .fifo_underrun(fifo_underrun),
      .byte_count_mismatch(byte_count_mismatch), .status_wr_done(status_wr_done),
      .status_wr_req(status_wr_req), .descriptor_status_word(descriptor_status_word),
      .tx_abort(tx_abort), .frame_check_omit(frame_check_omit), .irq(irq));
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   task automatic final_report();
      if (n_mismatch == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   // Pulse selectors; a ref argument may not take a non-blocking assignment
   localparam int P_SOFT = 0, P_PRE = 1, P_SFD = 2, P_LAST = 3, P_COL = 4, P_END = 5;
   localparam int P_DONE = 6;
   task automatic drive(input int k, input logic v);
      case (k)
         P_SOFT: soft_reset <= v;
         P_PRE: preamble_start <= v;
         P_SFD: sfd_done <= v;
         P_LAST: tx_last_byte <= v;
         P_COL: collision <= v;
         P_END: tx_end <= v;
         default: status_wr_done <= v;
      endcase
   endtask : drive
   task automatic pulse(input int k);
      @(posedge pclk) drive(k, 1'b1);
      @(posedge pclk) drive(k, 1'b0);
   endtask : pulse
   // One APB transfer; waits for pready under a bounded count
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 50) n_mismatch++;
   endtask : apb
   // One transmission; fin selects a normal end, else the block must abort by itself
   // gap idles after preamble and again after the delimiter
   task automatic xmit(input logic [15:0] cfg, input int ncol, input int ndef, input logic fin,
      input int gap);
      int n;
      n = 0;
      ab = 1'b0;
      @(posedge pclk) tx_start <= 1'b1;
      descriptor_config_word <= cfg;
      @(posedge pclk) tx_start <= 1'b0;
      if (ndef > 0) begin
         deferring <= 1'b1;
         repeat (ndef) begin
            @(posedge pclk);
            ab |= tx_abort;
         end
         deferring <= 1'b0;
      end
      if (fin) begin
         pulse(P_PRE);
         repeat (gap) @(posedge pclk);
         pulse(P_SFD);
         carrier_sense <= 1'b1;
         repeat (gap) @(posedge pclk);
      end
      repeat (ncol) pulse(P_COL);
      if (fin) begin
         pulse(P_LAST);
         pulse(P_END);
      end
      ab |= tx_abort;
      while (status_wr_req !== 1'b1 && n < 100) begin
         @(posedge pclk);
         ab |= tx_abort;
         n++;
      end
      if (n >= 100) n_mismatch++;
      @(posedge pclk) sw = descriptor_status_word;
      carrier_sense <= 1'b0;
      pulse(P_DONE);
      repeat (2) @(posedge pclk);
   endtask : xmit
   initial begin
      #(25 * 20000);
      n_mismatch++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, TCR_ADDR_TXCTL, 0); `CHK(r[15:0] & 16'h0313, 16'h0101)
      apb(1, TCR_ADDR_TXCTL, 32'hffff_ffff);
      apb(0, TCR_ADDR_TXCTL, 0); `CHK(r[15:0] & 16'hf313, 16'hf101)
      pulse(P_SOFT);
      apb(0, TCR_ADDR_TXCTL, 0); `CHK(r[15:0] & 16'hf313, 16'hf101)
      apb(1, TCR_ADDR_IMASK, 32'h0000_0003);
      apb(0, 12'h0fc, 0); `CHK(err, 1'b1)
      // Frame check omitted; collision in window when timed from the delimiter
      fifo_underrun <= 1'b1; byte_count_mismatch <= 1'b1;
      xmit(16'h2000, 1, 0, 1, TCR_SLOT_CYC * 3 / 4);
      `CHK(sw[15:11], 5'h01)
      `CHK(sw & 16'h0726, 16'h0006)
      apb(0, TCR_ADDR_TXCTL, 0); `CHK(r[15:12], 4'h2)
      `CHK(r[9] | r[5], 1'b0)
      `CHK(frame_check_omit, 1'b1)
      fifo_underrun <= 1'b0; byte_count_mismatch <= 1'b0;
      // Timer from preamble: the same gaps put the collision out of window
      xmit(16'h4000, 1, 0, 1, TCR_SLOT_CYC * 3 / 4);
      `CHK(sw[5], 1'b1)
      `CHK(frame_check_omit, 1'b0)
      apb(0, TCR_ADDR_TXCTL, 0); `CHK(r[5], 1'b0)
      // Timer enabled: long deferral aborts and flags
      xmit(16'h0000, 0, 60, 0, 0);
      `CHK(ab, 1'b1) `CHK(sw[10], 1'b1)
      // Timer disabled: the same deferral never flags; start clears bits 7, 6 and 1
      xmit(16'h1000, 0, 60, 1, 0);
      `CHK(ab, 1'b0) `CHK(sw[10], 1'b0)
      `CHK(sw[7] | sw[6] | sw[1], 1'b0)
      apb(1, TCR_ADDR_ISTAT, 32'h0000_0003);
      // Programmable interrupt plus sixteen collisions
      xmit(16'h8000, 16, 0, 0, 0);
      `CHK(ab, 1'b1) `CHK(sw[6], 1'b1)
      `CHK(irq, 1'b1)
      apb(0, TCR_ADDR_ISTAT, 0); `CHK(r[1:0], 2'b11)
      apb(1, TCR_ADDR_IMASK, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      apb(1, TCR_ADDR_ISTAT, 32'h0000_0003);
      apb(1, TCR_ADDR_IMASK, 32'h0000_0003);
      apb(0, TCR_ADDR_ISTAT, 0); `CHK(r[1:0], 2'b00)
      `CHK(irq, 1'b0)
      final_report();
   end
endmodule : tb_top
